/* File: hw/mfc_pkg.sv */
package mfc_pkg;
    // bus geometry
    localparam int MFC_ADDR_W = 16;
    localparam int MFC_DATA_W = 32;
    // register indices, byte address is four times the index
    localparam logic [15:0] MFC_CHAN_IDX = 16'h2878;
    localparam logic [15:0] MFC_GAIN_IDX = 16'h2879;
    localparam logic [15:0] MFC_THIRD_IDX = 16'h287A;
    localparam logic [15:0] MFC_CHAN_ADDR = {MFC_CHAN_IDX[13:0], 2'b00};
    localparam logic [15:0] MFC_GAIN_ADDR = {MFC_GAIN_IDX[13:0], 2'b00};
    localparam logic [15:0] MFC_THIRD_ADDR = {MFC_THIRD_IDX[13:0], 2'b00};
    // reset values
    localparam logic [7:0] MFC_CHAN_RST = 8'h00;
    localparam logic [7:0] MFC_GAIN_RST = 8'h00;
    localparam logic [7:0] MFC_THIRD_RST = 8'h00;
    // only the quarter select bit lives in the third register
    localparam logic [7:0] MFC_THIRD_MASK = 8'h20;
    // channel control bit positions
    localparam int MFC_CALC_BLOCK_BIT = 7;
    localparam int MFC_PHASE_EN_BIT = 6;
    localparam int MFC_SWAP_BIT = 5;
    localparam int MFC_CALC_EN_BIT = 4;
    localparam int MFC_AUX_EN_BIT = 3;
    localparam int MFC_I2_EN_BIT = 2;
    localparam int MFC_I1_EN_BIT = 1;
    localparam int MFC_VOLT_EN_BIT = 0;
    // gain control field positions
    localparam int MFC_I1_SIGN_BIT = 7;
    localparam int MFC_I1_EXP_LSB = 4;
    localparam int MFC_VOLT_SIGN_BIT = 3;
    localparam int MFC_VOLT_EXP_LSB = 0;
    localparam int MFC_EXP_W = 3;
    // third register field position
    localparam int MFC_QUARTER_BIT = 5;
    // largest legal gain exponent
    localparam logic [2:0] MFC_EXP_MAX = 3'h5;
    // sample widths
    localparam int MFC_SAMPLE_W = 16;
    localparam int MFC_OUT_W = 22;
    // bus answers
    localparam logic [1:0] MFC_RESP_OKAY = 2'h0;
    localparam logic [1:0] MFC_RESP_SLVERR = 2'h2;

    // raw digital inputs of the four channels
    typedef struct packed {
        logic signed [MFC_SAMPLE_W-1:0] voltage;
        logic signed [MFC_SAMPLE_W-1:0] current_a;
        logic signed [MFC_SAMPLE_W-1:0] current_b;
        logic signed [MFC_SAMPLE_W-1:0] aux;
    } mfc_samples_t;

    // gated channel samples, only voltage and first current are scaled
    typedef struct packed {
        logic signed [MFC_OUT_W-1:0] voltage;
        logic signed [MFC_OUT_W-1:0] first_current;
        logic signed [MFC_OUT_W-1:0] second_current;
        logic signed [MFC_OUT_W-1:0] aux;
    } mfc_channels_t;
endpackage

/* File: hw/mfc_top.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module mfc_top
    import mfc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic watchdog_reset,
    input wire logic [MFC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [MFC_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [MFC_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [MFC_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire mfc_samples_t samples_in,
    output mfc_channels_t channels_out,
    output logic calc_write_block_test,
    output logic phase_correction_enable,
    output logic power_rms_calc_enable
);

    // whole module state in one record
    typedef struct packed {
        logic [7:0] chan;
        logic [7:0] gain;
        logic [7:0] third;
        logic aw_held;
        logic [MFC_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [7:0] w_data;
        logic w_lane0;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [MFC_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        mfc_channels_t chans;
    } mfc_state_t;

    mfc_state_t state_reg; // registered state
    mfc_state_t state_next; // next state

    // clamp undefined exponent codes to the top legal gain
    function automatic logic [2:0] mfc_clamp_exp(input logic [2:0] code);
        logic [2:0] res;
        res = code;
        if (code > MFC_EXP_MAX) begin
            res = MFC_EXP_MAX;
        end
        return res;
    endfunction

    // scale a sample by a signed power of two, optionally a quarter of it
    // out width leaves one spare bit so negating full scale cannot wrap
    function automatic logic signed [MFC_OUT_W-1:0] mfc_scale(
        input logic signed [MFC_SAMPLE_W-1:0] smp,
        input logic neg,
        input logic [2:0] code,
        input logic quarter
    );
        logic signed [MFC_OUT_W-1:0] v;
        v = MFC_OUT_W'(smp);
        v = v <<< mfc_clamp_exp(code);
        if (quarter) begin
            v = v >>> 2;
        end
        if (neg) begin
            v = -v;
        end
        return v;
    endfunction

    // read mux, unused bits read zero
    function automatic logic [MFC_DATA_W-1:0] mfc_read(
        input mfc_state_t st,
        input logic [MFC_ADDR_W-1:0] addr
    );
        logic [MFC_DATA_W-1:0] d;
        d = '0;
        unique case (addr)
            MFC_CHAN_ADDR: d[7:0] = st.chan;
            MFC_GAIN_ADDR: d[7:0] = st.gain;
            MFC_THIRD_ADDR: d[7:0] = st.third;
            default: d = '0;
        endcase
        return d;
    endfunction

    // decode a register address
    function automatic logic mfc_mapped(input logic [MFC_ADDR_W-1:0] addr);
        return (addr == MFC_CHAN_ADDR) || (addr == MFC_GAIN_ADDR) ||
               (addr == MFC_THIRD_ADDR);
    endfunction

    // next-state logic: bus slave plus channel datapath
    always_comb begin
        logic aw_have;
        logic w_have;
        logic [MFC_ADDR_W-1:0] waddr;
        logic [7:0] wbyte;
        logic wlane;
        logic signed [MFC_SAMPLE_W-1:0] src_i1;
        logic signed [MFC_SAMPLE_W-1:0] src_i2;
        aw_have = 1'b0;
        w_have = 1'b0;
        waddr = '0;
        wbyte = '0;
        wlane = 1'b0;
        src_i1 = '0;
        src_i2 = '0;
        state_next = state_reg;

        // capture write address and data in either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata[7:0];
            state_next.w_lane0 = s_axi_wstrb[0];
        end
        aw_have = state_next.aw_held;
        w_have = state_next.w_held;
        waddr = state_next.aw_addr;
        wbyte = state_next.w_data;
        wlane = state_next.w_lane0;

        // response retires when master takes it
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // commit a write once both halves are in and no answer pending
        if (aw_have && w_have && !state_next.bvalid) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = mfc_mapped(waddr) ? MFC_RESP_OKAY : MFC_RESP_SLVERR;
            // only lane 0 carries the byte wide registers
            if (wlane) begin
                unique case (waddr)
                    MFC_CHAN_ADDR: state_next.chan = wbyte;
                    MFC_GAIN_ADDR: state_next.gain = wbyte;
                    MFC_THIRD_ADDR: state_next.third = wbyte & MFC_THIRD_MASK;
                    default: state_next.bresp = MFC_RESP_SLVERR;
                endcase
            end
        end
        // stall capture while a write is parked or answering
        state_next.awready = !state_next.aw_held && !state_next.bvalid;
        state_next.wready = !state_next.w_held && !state_next.bvalid;

        // read path, one in flight
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rdata = mfc_read(state_reg, s_axi_araddr);
            state_next.rresp = mfc_mapped(s_axi_araddr) ? MFC_RESP_OKAY : MFC_RESP_SLVERR;
        end
        state_next.arready = !state_next.rvalid;

        // current routing
        if (state_reg.chan[MFC_SWAP_BIT]) begin
            src_i1 = samples_in.current_b;
            src_i2 = samples_in.current_a;
        end else begin
            src_i1 = samples_in.current_a;
            src_i2 = samples_in.current_b;
        end

        // voltage channel, zeros while gated off
        if (state_reg.chan[MFC_VOLT_EN_BIT]) begin
            state_next.chans.voltage = mfc_scale(samples_in.voltage,
                state_reg.gain[MFC_VOLT_SIGN_BIT],
                state_reg.gain[MFC_VOLT_EXP_LSB +: MFC_EXP_W],
                state_reg.third[MFC_QUARTER_BIT]);
        end else begin
            state_next.chans.voltage = '0;
        end
        // first current channel
        if (state_reg.chan[MFC_I1_EN_BIT]) begin
            state_next.chans.first_current = mfc_scale(src_i1,
                state_reg.gain[MFC_I1_SIGN_BIT],
                state_reg.gain[MFC_I1_EXP_LSB +: MFC_EXP_W], 1'b0);
        end else begin
            state_next.chans.first_current = '0;
        end
        // second current channel, its gain sits outside this bank
        if (state_reg.chan[MFC_I2_EN_BIT]) begin
            state_next.chans.second_current = MFC_OUT_W'(src_i2);
        end else begin
            state_next.chans.second_current = '0;
        end
        // aux channel only processed while calculation runs
        if (state_reg.chan[MFC_AUX_EN_BIT] && state_reg.chan[MFC_CALC_EN_BIT]) begin
            state_next.chans.aux = MFC_OUT_W'(samples_in.aux);
        end else begin
            state_next.chans.aux = '0;
        end
    end

    // state register, watchdog reset acts like the reset pin
    always_ff @(posedge aclk) begin
        if (!aresetn || watchdog_reset) begin
            state_reg <= '0;
            state_reg.chan <= MFC_CHAN_RST;
            state_reg.gain <= MFC_GAIN_RST;
            state_reg.third <= MFC_THIRD_RST;
            state_reg.bresp <= MFC_RESP_OKAY;
            state_reg.rresp <= MFC_RESP_OKAY;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // outputs come straight from the state record
    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign channels_out = state_reg.chans;
    assign calc_write_block_test = state_reg.chan[MFC_CALC_BLOCK_BIT];
    assign phase_correction_enable = state_reg.chan[MFC_PHASE_EN_BIT];
    assign power_rms_calc_enable = state_reg.chan[MFC_CALC_EN_BIT];

    default clocking mfc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || watchdog_reset);

    // a write handshake on the control register
    sequence s_chan_write;
        s_axi_awvalid && s_axi_awready && s_axi_awaddr == MFC_CHAN_ADDR &&
        s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && ce;
    endsequence

    // a read handshake on the gain register
    sequence s_gain_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == MFC_GAIN_ADDR && ce;
    endsequence

    reset_defaults_a: assert property (@(posedge aclk) disable iff (1'b0)
        (!aresetn || watchdog_reset) |=> (state_reg.chan == MFC_CHAN_RST &&
        state_reg.gain == MFC_GAIN_RST && state_reg.third == MFC_THIRD_RST &&
        !s_axi_bvalid && !s_axi_rvalid))
        else $error("control bank not at defaults after reset");

    chan_write_a: assert property (
        s_chan_write |=> calc_write_block_test == $past(s_axi_wdata[7]) &&
        phase_correction_enable == $past(s_axi_wdata[6]) && s_axi_bvalid)
        else $error("channel control write not applied");

    calc_flag_a: assert property (
        s_chan_write |=> power_rms_calc_enable == $past(s_axi_wdata[MFC_CALC_EN_BIT]))
        else $error("calculation enable write not applied");

    gain_read_a: assert property (
        s_gain_read |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(state_reg.gain)})
        else $error("gain register readback wrong");

    swap_route_a: assert property (
        ce && state_reg.chan[MFC_SWAP_BIT] && state_reg.chan[MFC_I2_EN_BIT] |=>
        channels_out.second_current == MFC_OUT_W'($past(samples_in.current_a)))
        else $error("swapped current not routed to second channel");

    straight_route_a: assert property (
        ce && !state_reg.chan[MFC_SWAP_BIT] && state_reg.chan[MFC_I2_EN_BIT] |=>
        channels_out.second_current == MFC_OUT_W'($past(samples_in.current_b)))
        else $error("unswapped current not routed to second channel");

    volt_gate_a: assert property (
        ce && !state_reg.chan[MFC_VOLT_EN_BIT] |=> channels_out.voltage == '0)
        else $error("voltage channel not zeroed");

    i1_gate_a: assert property (
        ce && !state_reg.chan[MFC_I1_EN_BIT] |=> channels_out.first_current == '0)
        else $error("first current channel not zeroed");

    i2_gate_a: assert property (
        ce && !state_reg.chan[MFC_I2_EN_BIT] |=> channels_out.second_current == '0)
        else $error("second current channel not zeroed");

    aux_gate_a: assert property (
        ce && !(state_reg.chan[MFC_AUX_EN_BIT] && state_reg.chan[MFC_CALC_EN_BIT])
        |=> channels_out.aux == '0)
        else $error("aux channel not zeroed");

    i1_gain_a: assert property (
        ce && state_reg.chan[MFC_I1_EN_BIT] && !state_reg.chan[MFC_SWAP_BIT] &&
        state_reg.gain[7:4] == 4'hA |=>
        channels_out.first_current == -(MFC_OUT_W'($past(samples_in.current_a)) <<< 2))
        else $error("first current negative gain of four wrong");

    volt_sat_a: assert property (
        ce && state_reg.chan[MFC_VOLT_EN_BIT] && state_reg.gain[3:0] == 4'h7 &&
        state_reg.third[MFC_QUARTER_BIT] |=>
        channels_out.voltage == ((MFC_OUT_W'($past(samples_in.voltage)) <<< 5) >>> 2))
        else $error("saturated quarter voltage gain wrong");

    i1_sat_a: assert property (
        ce && state_reg.chan[MFC_I1_EN_BIT] && !state_reg.chan[MFC_SWAP_BIT] &&
        state_reg.gain[7:4] == 4'h6 |=>
        channels_out.first_current == (MFC_OUT_W'($past(samples_in.current_a)) <<< 5))
        else $error("saturated first current gain wrong");

    write_resp_a: assert property (
        s_axi_bvalid && !s_axi_bready && ce |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");

endmodule
`default_nettype wire

/* File: testbench/tb_mfc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mfc_top
    import mfc_pkg::*;
;
    logic aclk, aresetn, ce, watchdog_reset; // clock, resets, enable
    logic [15:0] s_axi_awaddr, s_axi_araddr; // bus addresses
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, s_axi_rdata; // bus data
    logic [3:0] s_axi_wstrb; // byte strobes
    logic [1:0] s_axi_bresp, s_axi_rresp; // bus answers
    mfc_samples_t samples_in; // raw channel inputs
    mfc_channels_t channels_out, ex; // design result and expectation
    logic calc_write_block_test, phase_correction_enable, power_rms_calc_enable;
    int miscompares, n_checks; // verdict counters
    logic [1:0] r; // last write answer
    // {channel control, gain control, third control}
    logic [23:0] cfg [8] = '{24'h0F0000, 24'h1F3500, 24'hFFDA20, 24'h277720,
                             24'h00FF00, 24'h066600, 24'h410C20, 24'h1EA800};
    // two sample sets, negative and extreme values
    logic [63:0] smp [2] = '{64'hCFC7_0ABC_F123_7FFF, 64'h8000_FFFF_7FFF_8001};

    mfc_top i_mfc_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .watchdog_reset(watchdog_reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .samples_in(samples_in), .channels_out(channels_out),
        .calc_write_block_test(calc_write_block_test),
        .phase_correction_enable(phase_correction_enable),
        .power_rms_calc_enable(power_rms_calc_enable));

    // 40 MHz clock
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    // compare and count; an unknown matches only the same unknown
    task automatic chk(input string nm, input logic [87:0] seen, input logic [87:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one write: address and data offered together, each released once taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        r = 2'h3;
        // wait for the answer however long it takes, the watchdog bounds it
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    // one read, checked against expected data and answer
    task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        // wait for the answer however long it takes, the watchdog bounds it
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        chk(nm, 88'(s_axi_rdata), 88'(e));
        chk({nm, " resp"}, 88'(s_axi_rresp), 88'(er));
        s_axi_rready <= 1'b0;
    endtask

    // gain path: saturate code, shift, optional quarter, then sign
    function automatic logic signed [MFC_OUT_W-1:0] scl(logic signed [15:0] s, logic ng,
                                                        logic [2:0] c, logic q);
        logic signed [MFC_OUT_W-1:0] v;
        v = MFC_OUT_W'(s);
        v = v <<< ((c > MFC_EXP_MAX) ? MFC_EXP_MAX : c);
        if (q) v = v >>> 2;
        return ng ? -v : v;
    endfunction

    // reference for all four channels from the register contents
    function automatic mfc_channels_t model(logic [7:0] c, logic [7:0] g, logic [7:0] t,
                                            mfc_samples_t s);
        mfc_channels_t m;
        m.voltage = c[0] ? scl(s.voltage, g[3], g[2:0], t[5]) : '0;
        m.first_current = c[1] ? scl(c[5] ? s.current_b : s.current_a, g[7], g[6:4], 1'b0) : '0;
        m.second_current = c[2] ? MFC_OUT_W'(c[5] ? s.current_a : s.current_b) : '0;
        m.aux = (c[3] && c[4]) ? MFC_OUT_W'(s.aux) : '0;
        return m;
    endfunction

    // single exit point for pass, fail and timeout
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog: whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        $display("[FAIL] watchdog expected done seen timeout");
        results();
    end

    // main sequence
    initial begin
        {aresetn, watchdog_reset, ce} = 3'b001;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        samples_in = smp[0];
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd("chan default", MFC_CHAN_ADDR, 32'h0, MFC_RESP_OKAY);
        rd("gain default", MFC_GAIN_ADDR, 32'h0, MFC_RESP_OKAY);
        rd("third default", MFC_THIRD_ADDR, 32'h0, MFC_RESP_OKAY);
        $display("test defaults done");
        // every configuration against both sample sets
        for (int j = 0; j < 2; j++) begin
            for (int i = 0; i < 8; i++) begin
                samples_in <= smp[j];
                wr(MFC_CHAN_ADDR, {24'hFFFFFF, cfg[i][23:16]}, 4'hF);
                wr(MFC_GAIN_ADDR, 32'(cfg[i][15:8]), 4'h1);
                wr(MFC_THIRD_ADDR, 32'(cfg[i][7:0]), 4'h1);
                rd("chan reg", MFC_CHAN_ADDR, 32'(cfg[i][23:16]), MFC_RESP_OKAY);
                rd("gain reg", MFC_GAIN_ADDR, 32'(cfg[i][15:8]), MFC_RESP_OKAY);
                rd("third reg", MFC_THIRD_ADDR, 32'(cfg[i][7:0] & 8'h20), MFC_RESP_OKAY);
                repeat (3) @(posedge aclk);
                ex = model(cfg[i][23:16], cfg[i][15:8], cfg[i][7:0], smp[j]);
                chk("voltage", 88'(channels_out.voltage), 88'(ex.voltage));
                chk("first", 88'(channels_out.first_current),
                    88'(ex.first_current));
                chk("second", 88'(channels_out.second_current),
                    88'(ex.second_current));
                chk("aux", 88'(channels_out.aux), 88'(ex.aux));
                chk("flags", 88'({calc_write_block_test, phase_correction_enable,
                    power_rms_calc_enable}),
                    88'({cfg[i][23], cfg[i][22], cfg[i][20]}));
            end
        end
        $display("test datapath done");
        // strobe off leaves register alone, unmapped place refused
        wr(MFC_GAIN_ADDR, 32'h0000_00AA, 4'hE);
        chk("no strobe resp", 88'(r), 88'(MFC_RESP_OKAY));
        wr(16'h0000, 32'h0000_00FF, 4'hF);
        chk("unmapped wr resp", 88'(r), 88'(MFC_RESP_SLVERR));
        rd("unmapped rd", 16'h0000, 32'h0, MFC_RESP_SLVERR);
        rd("gain kept", MFC_GAIN_ADDR, 32'(cfg[7][15:8]), MFC_RESP_OKAY);
        $display("test access done");
        // watchdog reset, then pin reset, both mid-run
        for (int k = 0; k < 2; k++) begin
            wr(MFC_CHAN_ADDR, 32'h0000_00FF, 4'h1);
            wr(MFC_GAIN_ADDR, 32'h0000_0055, 4'h1);
            wr(MFC_THIRD_ADDR, 32'h0000_0020, 4'h1);
            @(posedge aclk);
            if (k == 0) watchdog_reset <= 1'b1;
            else aresetn <= 1'b0;
            @(posedge aclk);
            watchdog_reset <= 1'b0;
            aresetn <= 1'b1;
            @(posedge aclk);
            chk("reset channels", 88'(channels_out), 88'h0);
            chk("reset flags", 88'({calc_write_block_test, phase_correction_enable,
                power_rms_calc_enable}), 88'h0);
            rd("chan reset", MFC_CHAN_ADDR, 32'h0, MFC_RESP_OKAY);
            rd("gain reset", MFC_GAIN_ADDR, 32'h0, MFC_RESP_OKAY);
            rd("third reset", MFC_THIRD_ADDR, 32'h0, MFC_RESP_OKAY);
        end
        $display("test resets done");
        // clock enable low freezes the channels while the inputs move
        wr(MFC_CHAN_ADDR, 32'h0000_001F, 4'h1);
        @(posedge aclk);
        ce <= 1'b0;
        samples_in <= smp[0];
        repeat (3) @(posedge aclk);
        ex = model(8'h1F, 8'h00, 8'h00, smp[1]);
        chk("frozen", 88'(channels_out), 88'(ex));
        ce <= 1'b1;
        repeat (3) @(posedge aclk);
        ex = model(8'h1F, 8'h00, 8'h00, smp[0]);
        chk("thawed", 88'(channels_out), 88'(ex));
        $display("test clock enable done");
        results();
    end
endmodule
`default_nettype wire
